//--- include/stepper_map.svh
`ifndef STEPPER_MAP_SVH
`define STEPPER_MAP_SVH
// ------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define STEP_HALF_NS 5000
`define STEP_HALF_CYC ((`STEP_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_US 100
`define WAKE_CYC (`WAKE_US * 1000 / `CLK_PERIOD_NS)
`define SYNC_IDLE_US 2000
`define SYNC_IDLE_CYC (`SYNC_IDLE_US * 1000 / `CLK_PERIOD_NS)
// ------------------------------------------------------------
// Sequencer
// ------------------------------------------------------------
`define POS_W 6
`define POS_HOME 6'h00
`define SLEEP_CODE 3'h7
`define INC_FULL 6'h10
`define INC_HALF 6'h08
`define INC_QUARTER 6'h04
`define INC_EIGHTH 6'h02
`define INC_SIXTEENTH 6'h01
// ------------------------------------------------------------
// Controller registers (byte addresses)
// ------------------------------------------------------------
`define REG_CTRL 12'h000
`define REG_STEP 12'h004
`define REG_STATUS 12'h008
`define CTRL_DUAL_EDGE 0
`define CTRL_DIRECTION 1
`define CTRL_SYNC_FORCE 2
`define CTRL_SYNC_AUTO 3
`define CTRL_RESET 4
`define CTRL_DISABLE 5
`define CTRL_EXC_LSB 8
`define CTRL_RESET_VAL 32'h0000_0000
`define STAT_BUSY 0
`define STAT_HOME 1
`define STAT_SYNC 2
`define STAT_WAKE 3
`define STAT_LEFT_LSB 16
`endif

//--- include/stepper_pkg.sv
package stepper_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wake = 2'b01,
    st_run = 2'b10
  } ctl_state_t;
  typedef logic [2:0] exc_code_t;
endpackage : stepper_pkg

//--- include/stepper_if.sv
`timescale 1ns/1ps
interface stepper_if;
  logic step_clk;
  logic reset_pin;
  logic sync_pin;
  logic direction_input;
  logic dual_edge_option;
  logic excitation_select_bit_a;
  logic excitation_select_bit_b;
  logic excitation_select_bit_c;
  logic reference_disable_pin;
  logic [3:0] phase_out;
  logic home_monitor_output;
  modport device (
    input step_clk, reset_pin, sync_pin, direction_input,
    input dual_edge_option, reference_disable_pin,
    input excitation_select_bit_a, excitation_select_bit_b,
    input excitation_select_bit_c,
    output phase_out, home_monitor_output
  );
  modport controller (
    output step_clk, reset_pin, sync_pin, direction_input,
    output dual_edge_option, reference_disable_pin,
    output excitation_select_bit_a, excitation_select_bit_b,
    output excitation_select_bit_c,
    input phase_out, home_monitor_output
  );
endinterface : stepper_if

//--- hw/stepper_device.sv
// Contract
// [R1] Power-on reset puts sequencer at home
// [R2] Reset input returns sequencer to home
// [R3] No clock edges: hold present excitation
// [R4] One step per qualifying clock edge
// [R5] Sync high selects synchronized chopping
// [R6] Controller avoids sync while rotating
// [R7] Sync only in dual-phase or hold
// [R8] Sync may derive from clock idle timeout
// [R9] Reference disable high: coast, sequencer runs
// [R10] Sleep code: coast, sequencer frozen
// [R11] Controller waits wake delay before edge; a run under way steps on through sleep and wake
// [R12] All device inputs driven defined levels
// [R13] Sleep code is a design parameter
`timescale 1ns/1ps
`include "stepper_map.svh"
module stepper_device #(
  parameter logic [2:0] SLEEP_CODE = `SLEEP_CODE // [R13]
) (
  // System
  input wire logic sys_clk,
  input wire logic rst,
  // Pins toward the controller
  stepper_if.device pins,
  // User side
  output logic [`POS_W-1:0] position,
  output logic coast,
  output logic chop_sync,
  output logic seq_frozen,
  output logic [15:0] step_total
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // Every pin is asynchronous to sys_clk; stage one feeds stage two only.
  logic [8:0] meta;
  logic [8:0] pin_s;
  logic [8:0] pin_raw;

  assign pin_raw = {pins.step_clk,
                    pins.reset_pin,
                    pins.sync_pin,
                    pins.direction_input,
                    pins.dual_edge_option,
                    pins.reference_disable_pin,
                    pins.excitation_select_bit_c,
                    pins.excitation_select_bit_b,
                    pins.excitation_select_bit_a};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta <= 9'h000;
    end else begin
      meta <= pin_raw;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_s <= 9'h000;
    end else begin
      pin_s <= meta;
    end
  end

  logic clk_s;
  logic reset_s;
  logic sync_s;
  logic dir_s;
  logic dual_s;
  logic ref_dis_s;
  stepper_pkg::exc_code_t exc_s;

  assign clk_s = pin_s[8];
  assign reset_s = pin_s[7];
  assign sync_s = pin_s[6];
  assign dir_s = pin_s[5];
  assign dual_s = pin_s[4];
  assign ref_dis_s = pin_s[3];
  assign exc_s = pin_s[2:0];

  // ------------------------------------------------------------
  // Clock edge qualification
  // ------------------------------------------------------------
  logic clk_prev;
  logic rise;
  logic fall;
  logic step_edge;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= clk_s;
    end
  end

  assign rise = clk_s & ~clk_prev;
  assign fall = ~clk_s & clk_prev;
  // Only a change of level counts, so a resting clock high or low holds
  assign step_edge = rise | (dual_s & fall); // [R3] [R4]

  // ------------------------------------------------------------
  // Disable modes
  // ------------------------------------------------------------
  logic code_disable_state;
  logic analog_disable_state;

  assign code_disable_state = (exc_s == SLEEP_CODE); // [R10] [R13]
  assign analog_disable_state = ref_dis_s; // [R9]

  // ------------------------------------------------------------
  // Step size per excitation code
  // ------------------------------------------------------------
  function automatic logic [`POS_W-1:0] step_inc(
    input stepper_pkg::exc_code_t code
  );
    unique case (code)
      3'h0: step_inc = `INC_FULL;
      3'h1: step_inc = `INC_HALF;
      3'h2: step_inc = `INC_QUARTER;
      3'h3: step_inc = `INC_EIGHTH;
      3'h4: step_inc = `INC_SIXTEENTH;
      default: step_inc = `INC_FULL;
    endcase
  endfunction : step_inc

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  logic [`POS_W-1:0] pos;
  logic [`POS_W-1:0] next_pos;
  logic [`POS_W-1:0] inc;

  assign inc = step_inc(exc_s);

  always_comb begin
    next_pos = pos;
    if (step_edge && !code_disable_state) begin // [R4] [R10]
      if (dir_s) begin
        next_pos = pos - inc;
      end else begin
        next_pos = pos + inc;
      end
    end
  end

  // Reset pin is synchronised, so a glitch that no rising sys_clk edge samples is lost
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pos <= `POS_HOME; // [R1]
    end else if (reset_s) begin
      pos <= `POS_HOME; // [R2]
    end else begin
      pos <= next_pos; // [R3] [R9]
    end
  end

  // ------------------------------------------------------------
  // Phase drive
  // ------------------------------------------------------------
  // Bits: {b_n, b, a_n, a}; quadrant p[5:4] alone picks the pair
  function automatic logic [3:0] phase_map(
    input logic [`POS_W-1:0] p
  );
    logic [3:0] base;
    base = 4'h0;
    unique case (p[5:4])
      2'b00: base = 4'h5;
      2'b01: base = 4'h6;
      2'b10: base = 4'ha;
      2'b11: base = 4'h9;
    endcase
    phase_map = base;
  endfunction : phase_map

  logic [3:0] drive;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      drive <= 4'h0;
    end else if (analog_disable_state || code_disable_state) begin
      drive <= 4'h0; // [R9] [R10]
    end else begin
      // A clock edge during reset must not flash a stepped phase
      drive <= phase_map(reset_s ? `POS_HOME : next_pos); // [R2]
    end
  end

  assign pins.phase_out = drive;

  // ------------------------------------------------------------
  // Home monitor and status
  // ------------------------------------------------------------
  logic home_mon;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      home_mon <= 1'b1; // [R1]
    end else begin
      home_mon <= reset_s || (next_pos == `POS_HOME); // [R2]
    end
  end

  assign pins.home_monitor_output = home_mon;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      position <= `POS_HOME;
    end else if (reset_s) begin
      position <= `POS_HOME;
    end else begin
      position <= next_pos;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      coast <= 1'b0;
      seq_frozen <= 1'b0;
    end else begin
      coast <= analog_disable_state || code_disable_state;
      seq_frozen <= code_disable_state;
    end
  end

  // Chopper sync flag; the analog chopper itself sits outside this block
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chop_sync <= 1'b0;
    end else begin
      chop_sync <= sync_s; // [R5]
    end
  end

  // Counts accepted steps, wraps; cleared with the sequencer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      step_total <= 16'h0000;
    end else if (reset_s) begin
      step_total <= 16'h0000;
    end else if (step_edge && !code_disable_state) begin
      step_total <= step_total + 16'h0001;
    end
  end

endmodule : stepper_device

//--- hw/stepper_controller.sv
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "stepper_map.svh"
module stepper_controller #(
  parameter int HALF_CYC = `STEP_HALF_CYC,
  parameter int WAKE_CYC = `WAKE_CYC,
  parameter int SYNC_IDLE_CYC = `SYNC_IDLE_CYC
) (
  // System
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins toward the device
  stepper_if.controller pins
);

  // ------------------------------------------------------------
  // Register access
  // ------------------------------------------------------------
  logic [31:0] ctrl;
  logic [15:0] left;
  logic busy;
  logic sync_q;
  logic wake_pend;
  logic home_s;
  logic home_m;
  logic wr;
  logic mapped;
  logic [31:0] rd;

  assign wr = psel & penable & pready & pwrite;
  assign mapped = (paddr == `REG_CTRL) | (paddr == `REG_STEP) |
                  (paddr == `REG_STATUS);

  always_comb begin
    rd = 32'h0000_0000;
    unique case (paddr)
      `REG_CTRL: rd = ctrl;
      `REG_STEP: rd = {16'h0000, left};
      `REG_STATUS: begin
        rd[`STAT_BUSY] = busy;
        rd[`STAT_HOME] = home_s;
        rd[`STAT_SYNC] = sync_q;
        rd[`STAT_WAKE] = wake_pend;
        rd[`STAT_LEFT_LSB +: 16] = left;
      end
      default: rd = 32'h0000_0000;
    endcase
  end

  // No wait state: data is latched in setup, pready high in the first access cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      prdata <= (psel & ~penable & ~pwrite) ? rd : 32'h0000_0000;
      pslverr <= psel & ~penable & ~mapped;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl <= `CTRL_RESET_VAL;
    end else if (wr && paddr == `REG_CTRL) begin
      ctrl <= pwdata & 32'h0000_073f;
    end
  end

  // ------------------------------------------------------------
  // Pin drive; every pin has a defined level from reset
  // ------------------------------------------------------------
  logic sleeping;
  assign sleeping = ctrl[`CTRL_DISABLE] |
                    (ctrl[`CTRL_EXC_LSB +: 3] == `SLEEP_CODE);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pins.reset_pin <= 1'b0; // [R12]
      pins.direction_input <= 1'b0;
      pins.dual_edge_option <= 1'b0;
      pins.reference_disable_pin <= 1'b0;
      pins.excitation_select_bit_a <= 1'b0;
      pins.excitation_select_bit_b <= 1'b0;
      pins.excitation_select_bit_c <= 1'b0;
    end else begin
      pins.reset_pin <= ctrl[`CTRL_RESET];
      pins.direction_input <= ctrl[`CTRL_DIRECTION];
      pins.dual_edge_option <= ctrl[`CTRL_DUAL_EDGE];
      pins.reference_disable_pin <= ctrl[`CTRL_DISABLE];
      pins.excitation_select_bit_a <= ctrl[`CTRL_EXC_LSB];
      pins.excitation_select_bit_b <= ctrl[`CTRL_EXC_LSB + 1];
      pins.excitation_select_bit_c <= ctrl[`CTRL_EXC_LSB + 2];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      home_m <= 1'b0;
      home_s <= 1'b0;
    end else begin
      home_m <= pins.home_monitor_output;
      home_s <= home_m;
    end
  end

  // ------------------------------------------------------------
  // Wake delay after either sleep is released
  // ------------------------------------------------------------
  logic [31:0] wake_cnt;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wake_cnt <= 32'h0000_0000;
    end else if (sleeping) begin
      wake_cnt <= WAKE_CYC[31:0]; // [R11]
    end else if (wake_cnt != 32'h0000_0000) begin
      wake_cnt <= wake_cnt - 32'h0000_0001;
    end
  end
  assign wake_pend = (wake_cnt != 32'h0000_0000);

  // ------------------------------------------------------------
  // Step clock generator
  // ------------------------------------------------------------
  stepper_pkg::ctl_state_t state;
  logic [31:0] half_cnt;
  logic clk_q;
  logic tick;
  logic qual;
  assign tick = (half_cnt == 32'h0000_0000);
  // Edge produced by this toggle: rising always steps, falling in dual
  assign qual = ~clk_q | ctrl[`CTRL_DUAL_EDGE];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= stepper_pkg::st_idle;
      left <= 16'h0000;
      clk_q <= 1'b0;
      half_cnt <= 32'h0000_0000;
    end else begin
      unique case (state)
        stepper_pkg::st_idle: begin
          if (wr && paddr == `REG_STEP && pwdata[15:0] != 16'h0000) begin
            left <= pwdata[15:0];
            state <= stepper_pkg::st_wake;
          end
        end
        stepper_pkg::st_wake: begin
          if (!wake_pend && !sleeping) begin // [R11]
            half_cnt <= HALF_CYC[31:0] - 32'h0000_0001;
            state <= stepper_pkg::st_run;
          end
        end
        stepper_pkg::st_run: begin
          if (!tick) begin
            half_cnt <= half_cnt - 32'h0000_0001;
          end else if (left == 16'h0000) begin
            if (clk_q && !ctrl[`CTRL_DUAL_EDGE]) begin
              clk_q <= 1'b0;
            end
            state <= stepper_pkg::st_idle;
          end else begin
            clk_q <= ~clk_q;
            half_cnt <= HALF_CYC[31:0] - 32'h0000_0001;
            if (qual) begin
              left <= left - 16'h0001;
            end
          end
        end
        default: state <= stepper_pkg::st_idle;
      endcase
    end
  end
  assign busy = (state != stepper_pkg::st_idle);
  assign pins.step_clk = clk_q;

  // ------------------------------------------------------------
  // Chopping sync
  // ------------------------------------------------------------
  logic [31:0] idle_cnt;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idle_cnt <= 32'h0000_0000;
    end else if (busy) begin
      idle_cnt <= 32'h0000_0000; // [R8]
    end else if (idle_cnt != SYNC_IDLE_CYC[31:0]) begin
      idle_cnt <= idle_cnt + 32'h0000_0001;
    end
  end

  // Never while stepping; hold only, so any excitation is safe then
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= ~busy & ~sleeping & (ctrl[`CTRL_SYNC_FORCE] | // [R6] [R7]
                (ctrl[`CTRL_SYNC_AUTO] &
                 (idle_cnt == SYNC_IDLE_CYC[31:0]))); // [R8]
    end
  end
  assign pins.sync_pin = sync_q;

endmodule : stepper_controller

//--- bench/stepper_sva.sv
`timescale 1ns/1ps
`include "stepper_map.svh"
module stepper_sva #(
  parameter logic [2:0] SLEEP_CODE = `SLEEP_CODE
) (
  // System
  input wire logic sys_clk,
  input wire logic rst,
  // Pins between the two ends
  input wire logic step_clk,
  input wire logic reset_pin,
  input wire logic sync_pin,
  input wire logic direction_input,
  input wire logic dual_edge_option,
  input wire logic excitation_select_bit_a,
  input wire logic excitation_select_bit_b,
  input wire logic excitation_select_bit_c,
  input wire logic reference_disable_pin,
  input wire logic [3:0] phase_out,
  input wire logic home_monitor_output
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  logic [2:0] exc;
  logic [8:0] pin_bus;
  logic quiet;
  logic sleeping;
  assign exc = {excitation_select_bit_c, excitation_select_bit_b,
                excitation_select_bit_a};
  assign pin_bus = {step_clk, reset_pin, sync_pin, direction_input,
                    dual_edge_option, reference_disable_pin, exc};
  // Full steps only: smaller steps may stay inside one phase quadrant
  assign quiet = !reset_pin && !reference_disable_pin && exc == 3'h0;
  assign sleeping = exc == SLEEP_CODE;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_por_home: assert property ($fell(rst) |->
    home_monitor_output && phase_out == 4'h0)
    else $error("not at home after power-on reset");
  a_pin_home: assert property (reset_pin [*4] |-> home_monitor_output)
    else $error("reset pin did not bring the sequencer home");
  a_hold_still: assert property ($stable(pin_bus) [*6] |->
    $stable(phase_out))
    else $error("drive changed with no input activity");
  a_rise_steps: assert property ($rose(step_clk) && quiet |->
    ##[2:6] $changed(phase_out))
    else $error("rising clock edge did not step");
  a_fall_ignored: assert property (!dual_edge_option && quiet &&
    $fell(step_clk) |-> ##2 $stable(phase_out) [*3])
    else $error("falling edge stepped in rising-only mode");
  a_dual_steps: assert property (dual_edge_option && quiet &&
    $fell(step_clk) |-> ##[2:6] $changed(phase_out))
    else $error("falling edge did not step in dual-edge mode");
  a_edge_width: assert property ($changed(step_clk) |=>
    $stable(step_clk) [*2])
    else $error("step clock level shorter than three cycles");
  a_disable_coast: assert property (reference_disable_pin [*5] |->
    phase_out == 4'h0)
    else $error("outputs driven during analog disable");
  a_sleep_coast: assert property (sleeping [*5] |->
    phase_out == 4'h0)
    else $error("outputs driven during sleep code");
  a_sync_still: assert property ($changed(step_clk) |-> !sync_pin)
    else $error("sync high while stepping");
endmodule : stepper_sva

//--- bench/tb_top.sv
`timescale 1ns/1ps
`include "stepper_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  miscompares++; \
  $display("ERROR at %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb_top;
  logic sys_clk, rst, psel, penable, pwrite, pslverr, pready, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [5:0] position, exp_pos, inc;
  logic [15:0] step_total, total;
  logic [3:0] ph;
  logic coast, chop_sync, seq_frozen;
  int miscompares = 0;
  int checks_done = 0;
  stepper_if bus ();
  stepper_controller #(.HALF_CYC(4), .WAKE_CYC(16), .SYNC_IDLE_CYC(32))
    stepper_controller_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(bus));
  stepper_device stepper_device_inst (.sys_clk(sys_clk), .rst(rst),
    .pins(bus), .position(position), .coast(coast), .chop_sync(chop_sync),
    .seq_frozen(seq_frozen), .step_total(step_total));
  stepper_sva stepper_sva_inst (.sys_clk(sys_clk), .rst(rst),
    .step_clk(bus.step_clk), .reset_pin(bus.reset_pin),
    .sync_pin(bus.sync_pin), .direction_input(bus.direction_input),
    .dual_edge_option(bus.dual_edge_option),
    .excitation_select_bit_a(bus.excitation_select_bit_a),
    .excitation_select_bit_b(bus.excitation_select_bit_b),
    .excitation_select_bit_c(bus.excitation_select_bit_c),
    .reference_disable_pin(bus.reference_disable_pin),
    .phase_out(bus.phase_out), .home_monitor_output(bus.home_monitor_output));
  always #5 sys_clk = ~sys_clk;
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  // Request held until pready is seen high at the rising edge
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wait_idle;
    rdata = 32'h1;
    for (int i = 0; i < 400 && rdata[`STAT_BUSY] !== 1'b0; i++) begin
      xfer(1'b0, `REG_STATUS, 32'h0);
    end
    `CHK(rdata[`STAT_BUSY], 1'b0)
    repeat (10) @(posedge sys_clk);
  endtask : wait_idle
  function automatic logic [31:0] ctrl_word(input logic [2:0] c,
                                            input logic [5:0] f);
    return {21'h0, c, 2'b00, f};
  endfunction : ctrl_word
  task automatic conclude;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    xfer(1'b0, `REG_CTRL, 32'h0);
    `CHK(rdata, `CTRL_RESET_VAL)
    `CHK(position, `POS_HOME)
    `CHK(bus.home_monitor_output, 1'b1)
    `CHK({bus.step_clk, bus.reset_pin, bus.sync_pin}, 3'h0)
    $display("power-on test done");
    exp_pos = `POS_HOME;
    total = 16'h0;
    // Every stepping code, edge modes alternating, last one reversed
    for (int c = 0; c < 7; c++) begin
      inc = (c == 1) ? `INC_HALF : (c == 2) ? `INC_QUARTER :
            (c == 3) ? `INC_EIGHTH : (c == 4) ? `INC_SIXTEENTH : `INC_FULL;
      xfer(1'b1, `REG_CTRL, ctrl_word(3'(c), {4'h0, c == 6, ~c[0]}));
      xfer(1'b1, `REG_STEP, 32'h3);
      wait_idle();
      exp_pos = (c == 6) ? exp_pos - 6'(3 * inc) : exp_pos + 6'(3 * inc);
      total = total + 16'h3;
      `CHK(position, exp_pos)
      `CHK(step_total, total)
      ph = bus.phase_out;
      repeat (30) @(posedge sys_clk);
      `CHK(bus.phase_out, ph)
    end
    $display("stepping test done");
    xfer(1'b1, `REG_CTRL, ctrl_word(3'h0, 6'h10));
    repeat (6) @(posedge sys_clk);
    `CHK(position, `POS_HOME)
    `CHK(bus.home_monitor_output, 1'b1)
    `CHK(step_total, 16'h0)
    xfer(1'b0, `REG_STATUS, 32'h0);
    `CHK(rdata[`STAT_HOME], 1'b1)
    exp_pos = `POS_HOME;
    $display("reset pin test done");
    // Disable lands mid-run; the controller starts no run while asleep
    xfer(1'b1, `REG_STEP, 32'h2);
    xfer(1'b1, `REG_CTRL, ctrl_word(3'h0, 6'h20));
    repeat (6) @(posedge sys_clk);
    `CHK(coast, 1'b1)
    wait_idle();
    exp_pos = exp_pos + 6'h20;
    `CHK(position, exp_pos)
    `CHK(bus.phase_out, 4'h0)
    $display("analog disable test done");
    xfer(1'b1, `REG_CTRL, ctrl_word(`SLEEP_CODE, 6'h0));
    repeat (6) @(posedge sys_clk);
    `CHK(coast, 1'b1)
    `CHK(seq_frozen, 1'b1)
    xfer(1'b1, `REG_STEP, 32'h2);
    repeat (60) @(posedge sys_clk);
    `CHK(position, exp_pos)
    xfer(1'b0, `REG_STATUS, 32'h0);
    `CHK(rdata[`STAT_BUSY], 1'b1)
    xfer(1'b1, `REG_CTRL, 32'h0);
    xfer(1'b0, `REG_STATUS, 32'h0);
    `CHK(rdata[`STAT_WAKE], 1'b1)
    wait_idle();
    exp_pos = exp_pos + 6'h20;
    `CHK(position, exp_pos)
    `CHK(coast, 1'b0)
    $display("sleep code test done");
    xfer(1'b1, `REG_CTRL, ctrl_word(3'h0, 6'h04));
    repeat (6) @(posedge sys_clk);
    `CHK(bus.sync_pin, 1'b1)
    `CHK(chop_sync, 1'b1)
    xfer(1'b1, `REG_CTRL, ctrl_word(3'h0, 6'h08));
    xfer(1'b1, `REG_STEP, 32'h4);
    repeat (20) @(posedge sys_clk);
    `CHK(bus.sync_pin, 1'b0)
    wait_idle();
    `CHK(bus.sync_pin, 1'b0)
    repeat (40) @(posedge sys_clk);
    `CHK(bus.sync_pin, 1'b1)
    `CHK(chop_sync, 1'b1)
    xfer(1'b0, `REG_STATUS, 32'h0);
    `CHK(rdata[`STAT_SYNC], 1'b1)
    $display("sync test done");
    xfer(1'b0, 12'h00c, 32'h0);
    `CHK({rerr, rdata}, {1'b1, 32'h0})
    xfer(1'b1, `REG_CTRL, 32'hffff_ffff);
    xfer(1'b0, `REG_CTRL, 32'h0);
    `CHK(rdata, 32'h0000_073f)
    xfer(1'b1, `REG_CTRL, 32'h0);
    xfer(1'b1, `REG_STEP, 32'h0);
    xfer(1'b0, `REG_STATUS, 32'h0);
    `CHK(rdata[`STAT_BUSY], 1'b0)
    $display("register test done");
    conclude();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    conclude();
  end
endmodule : tb_top
